/* rtl/tsr_defines.svh */
// Bit positions, word counts and codes of the tape status report
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
`define TSR_NUM_WORDS      6
`define TSR_W1_FILE_MARK   0
`define TSR_W1_LOAD_POINT  1
`define TSR_W1_END_TAPE    2
`define TSR_W1_SINGLE_TRK  3
`define TSR_W1_REJECT      4
`define TSR_W1_NO_RING     5
`define TSR_W1_UNRECOVERED 6
`define TSR_W1_ONLINE      7
`define TSR_W2_GCR         0
`define TSR_W2_UNK_DENS    1
`define TSR_W2_PARITY      2
`define TSR_W2_TIMING      3
`define TSR_W2_RUNAWAY     4
`define TSR_W2_DOOR        5
`define TSR_W2_TRANSP      6
`define TSR_W2_IMMED       7
`define TSR_W3_PE          0
`define TSR_W3_NRZI        1
`define TSR_W3_POWER       2
`define TSR_W3_CMD_PAR     3
`define TSR_W3_POS_LOST    4
`define TSR_W3_FORMATTER   5
`define TSR_W3_SERVO       6
`define TSR_W3_CTRL        7
`define TSR_W4_RETRY_LSB   3
`define TSR_W4_DETAIL_LSB  0
`define TSR_DET_NONE       3'h0
`define TSR_DET_DEVICE     3'h2
`define TSR_DET_PROTOCOL   3'h3
`define TSR_DET_PRIOR      3'h5
`define TSR_DET_SELFTEST   3'h7
`endif

/* rtl/tsr_pkg.sv */
// Types shared by the tape status report logic
package tsr_pkg;
  typedef struct packed {
    logic file_mark_flag;
    logic load_point_flag;
    logic end_of_tape_flag;
    logic single_track_error;
    logic unrecovered_error;
    logic no_write_ring;
    logic online;
    logic gcr_mode;
    logic unknown_density;
    logic parity_error;
    logic timing_error;
    logic tape_runaway;
    logic door_open;
    logic pe_mode;
    logic nrzi_mode;
    logic position_lost;
    logic formatter_error;
    logic servo_error;
    logic controller_error;
  } tsr_cond_t;

  typedef struct packed {
    logic reject;
    logic cmd_parity;
    logic power_restored;
    logic transparent;
  } tsr_event_t;

  typedef enum logic [1:0] {
    TSR_IDLE,
    TSR_SEND,
    TSR_WAIT
  } tsr_state_t;
endpackage : tsr_pkg

/* rtl/tsr_status_report.sv */
// Tape drive status report: assembles six status bytes and sends five, or all six in immediate report mode, to the host
//
// Functional notes
// - Word 1 bits 0-2 file mark, load point, END_OF_TAPE_FLAG.
// - Word 1 bit3 recovered, bit6 unrecovered error.
// - Word 1 bit4 reject, reason in word 4.
// - Word 1 bit5 no ring, bit7 online.
// - Word 2 bit0 GCR, bit1 unknown density.
// - Word 3 bit0 PE, bit1 NRZI.
// - Word 2 parity, timing, runaway bits 2-4.
// - Word 2 door, transparent, immediate mode bits.
// - Word 3 power, command parity, position lost.
// - Word 3 formatter, servo, controller errors.
// - Word 4 bits 3-7 retry count.
// - Word 4 bits 0-2 reject detail code.
// - Codes 010, 011, 101 refer to word 5.
// - 111 self-test; other codes no detail.
// - Word 5 carries binary specific error code.
// - Word 6 only in immediate report mode.
// - Word 6 counts commands since failed one.
`timescale 1ns/1ns
`include "tsr_defines.svh"

module tsr_status_report #(
  parameter int RETRY_W = 5                          // Width of retry count field
) (
  input  wire logic               clock,             // 100 MHz clock
  input  wire logic               reset,             // Synchronous, active high
  input  wire tsr_pkg::tsr_cond_t cond,              // Live drive conditions
  input  wire tsr_pkg::tsr_event_t evt,              // One-cycle error events
  input  wire logic               immediate_mode,    // Immediate report enabled
  input  wire logic [2:0]         reject_detail,     // Detail code with reject event
  input  wire logic [7:0]         error_code,        // Specific error code with event
  input  wire logic [RETRY_W-1:0] retry_count,       // Retries of last read/write
  input  wire logic               retry_valid,       // Read/write just finished
  input  wire logic               cmd_issued,        // Host issued a command
  input  wire logic               status_req,        // Host asks for a status report
  input  wire logic               byte_ack,          // Host took the current byte
  output logic [8:1]              dio,               // Data lines, bit 0 on line 8
  output logic                    byte_valid,        // Byte on dio is valid
  output logic                    report_done        // Pulse after last byte taken
);

  // ---------------------------------------------------------------
  // Latched events
  // ---------------------------------------------------------------
  tsr_pkg::tsr_event_t ev_q, ev_d;
  logic [2:0]          det_q, det_d;
  logic [7:0]          err_q, err_d;
  logic [RETRY_W-1:0]  retry_q, retry_d;
  logic [7:0]          cmd_cnt_q, cmd_cnt_d;
  logic                tracking_q, tracking_d;

  tsr_pkg::tsr_state_t state_q, state_d;
  logic [2:0]          idx_q, idx_d;
  logic [2:0]          last_idx;
  logic [7:0]          word [`TSR_NUM_WORDS];
  logic [7:0]          dio_d;
  logic                valid_d, done_d;
  logic                clear_evt;

  // Events are cleared once reported; a new event in that cycle still wins
  assign clear_evt = (state_q == tsr_pkg::TSR_WAIT) && byte_ack &&
                     (idx_q >= last_idx);

  // Set wins over the end-of-report clear
  always_comb
  begin
    ev_d = clear_evt ? '0 : ev_q;
    ev_d = ev_d | evt;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ev_q <= '0;
    end
    else
    begin
      ev_q <= ev_d;
    end
  end

  // ---------------------------------------------------------------
  // Reject detail, error code and retry count
  // ---------------------------------------------------------------
  // Held until the next event replaces them; a report does not clear them
  always_comb
  begin
    det_d   = det_q;
    err_d   = err_q;
    retry_d = retry_q;
    if (evt.reject)
    begin
      det_d = reject_detail;
    end
    if (evt.reject || evt.transparent)
    begin
      err_d = error_code;
    end
    // Only the most recent read or write counts
    if (retry_valid)
    begin
      retry_d = retry_count;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      det_q   <= `TSR_DET_NONE;
      err_q   <= 8'h00;
      retry_q <= '0;
    end
    else
    begin
      det_q   <= det_d;
      err_q   <= err_d;
      retry_q <= retry_d;
    end
  end

  // ---------------------------------------------------------------
  // Failed-command distance
  // ---------------------------------------------------------------
  // Restarts at the failure, counts later commands, saturates at 255
  always_comb
  begin
    tracking_d = tracking_q;
    cmd_cnt_d  = cmd_cnt_q;
    if (evt.transparent)
    begin
      tracking_d = 1'b1;
      cmd_cnt_d  = 8'h00;
    end
    else if (tracking_q && cmd_issued && cmd_cnt_q != 8'hff)
    begin
      cmd_cnt_d = cmd_cnt_q + 8'h01;
    end
    // Tracking stops with the report unless a new failure arrives
    if (clear_evt && !evt.transparent)
    begin
      tracking_d = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      tracking_q <= 1'b0;
      cmd_cnt_q  <= 8'h00;
    end
    else
    begin
      tracking_q <= tracking_d;
      cmd_cnt_q  <= cmd_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Status word assembly
  // ---------------------------------------------------------------
  // Live levels are taken as each byte is loaded, so a byte shows
  // the drive as it stood when that byte went out
  always_comb
  begin
    word[0] = 8'h00;
    word[0][`TSR_W1_FILE_MARK]   = cond.file_mark_flag;
    word[0][`TSR_W1_LOAD_POINT]  = cond.load_point_flag;
    word[0][`TSR_W1_END_TAPE]    = cond.end_of_tape_flag;
    word[0][`TSR_W1_SINGLE_TRK]  = cond.single_track_error;
    word[0][`TSR_W1_UNRECOVERED] = cond.unrecovered_error;
    word[0][`TSR_W1_REJECT]      = ev_q.reject;
    word[0][`TSR_W1_NO_RING]     = cond.no_write_ring;
    word[0][`TSR_W1_ONLINE]      = cond.online;

    word[1] = 8'h00;
    word[1][`TSR_W2_GCR]         = cond.gcr_mode;
    word[1][`TSR_W2_UNK_DENS]    = cond.unknown_density;
    word[1][`TSR_W2_PARITY]      = cond.parity_error;
    word[1][`TSR_W2_TIMING]      = cond.timing_error;
    word[1][`TSR_W2_RUNAWAY]     = cond.tape_runaway;
    word[1][`TSR_W2_DOOR]        = cond.door_open;
    word[1][`TSR_W2_TRANSP]      = ev_q.transparent;
    word[1][`TSR_W2_IMMED]       = immediate_mode;

    word[2] = 8'h00;
    word[2][`TSR_W3_PE]          = cond.pe_mode;
    word[2][`TSR_W3_NRZI]        = cond.nrzi_mode;
    word[2][`TSR_W3_POWER]       = ev_q.power_restored;
    word[2][`TSR_W3_CMD_PAR]     = ev_q.cmd_parity;
    word[2][`TSR_W3_POS_LOST]    = cond.position_lost;
    word[2][`TSR_W3_FORMATTER]   = cond.formatter_error;
    word[2][`TSR_W3_SERVO]       = cond.servo_error;
    word[2][`TSR_W3_CTRL]        = cond.controller_error;

    word[3] = 8'h00;
    word[3][`TSR_W4_RETRY_LSB +: RETRY_W]  = retry_q;
    // Codes 010/011/101 send the host to word 5; 111 is self-test failure
    word[3][`TSR_W4_DETAIL_LSB +: 3]       = det_q;
    word[4] = err_q;
    word[5] = cmd_cnt_q;
  end

  // ---------------------------------------------------------------
  // Report length
  // ---------------------------------------------------------------
  // Sixth byte only goes out in immediate report mode
  assign last_idx = immediate_mode ? 3'(`TSR_NUM_WORDS - 1)
                                   : 3'(`TSR_NUM_WORDS - 2);

  // ---------------------------------------------------------------
  // Word bit to data line mapping
  // ---------------------------------------------------------------
  logic [7:0]          cur_word;
  logic [8:1]          cur_lines;

  // Index stays within the six words; the end test uses >=
  assign cur_word = word[idx_q];

  // Bit 0 onto line 8, bit 7 onto line 1
  for (genvar b = 0; b < 8; b++)
  begin : g_line
    assign cur_lines[8 - b] = cur_word[b];
  end

  // ---------------------------------------------------------------
  // Byte transfer to host
  // ---------------------------------------------------------------
  // Two steps per byte: load it, then hold it until the host takes it
  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    dio_d   = dio;
    valid_d = 1'b0;
    done_d  = 1'b0;
    case (state_q)
      tsr_pkg::TSR_IDLE:
      begin
        // A request while a report runs is never seen here
        if (status_req)
        begin
          idx_d   = 3'h0;
          state_d = tsr_pkg::TSR_SEND;
        end
      end
      tsr_pkg::TSR_SEND:
      begin
        dio_d   = cur_lines;
        valid_d = 1'b1;
        state_d = tsr_pkg::TSR_WAIT;
      end
      tsr_pkg::TSR_WAIT:
      begin
        valid_d = 1'b1;
        if (byte_ack)
        begin
          valid_d = 1'b0;
          // A mode drop after word five cannot run the index past the end
          if (idx_q >= last_idx)
          begin
            done_d  = 1'b1;
            state_d = tsr_pkg::TSR_IDLE;
          end
          else
          begin
            idx_d   = idx_q + 3'h1;
            state_d = tsr_pkg::TSR_SEND;
          end
        end
      end
      default:
      begin
        state_d = tsr_pkg::TSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q     <= tsr_pkg::TSR_IDLE;
      idx_q       <= 3'h0;
      dio         <= 8'h00;
      byte_valid  <= 1'b0;
      report_done <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      idx_q       <= idx_d;
      dio         <= dio_d;
      byte_valid  <= valid_d;
      report_done <= done_d;
    end
  end

endmodule : tsr_status_report

/* sim/tsr_report_chk.sv */
// Port checks of the tape status report
`timescale 1ns/1ns
module tsr_report_chk (
  input wire logic               clock,          // Clock
  input wire logic               reset,          // Reset
  input wire tsr_pkg::tsr_cond_t cond,           // Levels
  input wire logic               immediate_mode, // Mode
  input wire logic               status_req,     // Request
  input wire logic               byte_ack,       // Ack
  input wire logic [8:1]         dio,            // Lines
  input wire logic               byte_valid,     // Valid
  input wire logic               report_done     // Done
);
  // ------------------------------------------------
  // Report tracking
  // ------------------------------------------------
  logic       busy_q, busy_d, idle, take;
  logic [2:0] acks_q, acks_d;
  assign idle = !busy_q || report_done;
  assign take = byte_valid && byte_ack;
  always_comb
  begin
    busy_d = (status_req && idle) || (busy_q && !report_done);
    acks_d = report_done ? 3'h0 : acks_q + 3'(take);
  end
  always_ff @(posedge clock)
  begin
    busy_q <= reset ? 1'b0 : busy_d;
    acks_q <= reset ? 3'h0 : acks_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_first_byte: assert property (idle && status_req |=> !byte_valid ##1 byte_valid)
    else $error("first byte late");
  a_byte_holds: assert property (byte_valid && !byte_ack |=> byte_valid && $stable(dio))
    else $error("byte not held");
  a_byte_drops: assert property (take |=> !byte_valid)
    else $error("valid stayed after ack");
  a_next_byte: assert property (take && acks_q < 3'h4 |=> !report_done ##1 byte_valid)
    else $error("next byte late");
  a_done_count: assert property (report_done |-> acks_q == ($past(immediate_mode) ? 3'h6 : 3'h5))
    else $error("wrong byte count");
  a_done_pulse: assert property (report_done |=> !report_done)
    else $error("done too long");
  a_word_one: assert property (byte_valid && acks_q == 3'h0 |-> dio == {cond.file_mark_flag,
    cond.load_point_flag, cond.end_of_tape_flag, cond.single_track_error, dio[4],
    cond.no_write_ring, cond.unrecovered_error, cond.online}) else $error("word one wrong");
  a_word_two: assert property (byte_valid && acks_q == 3'h1 |-> dio == {cond.gcr_mode,
    cond.unknown_density, cond.parity_error, cond.timing_error, cond.tape_runaway,
    cond.door_open, dio[2], immediate_mode}) else $error("word two wrong");
  a_word_three: assert property (byte_valid && acks_q == 3'h2 |-> dio == {cond.pe_mode,
    cond.nrzi_mode, dio[6], dio[5], cond.position_lost, cond.formatter_error,
    cond.servo_error, cond.controller_error}) else $error("word three wrong");
  c_six: cover property (report_done && acks_q == 3'h6);
  c_five: cover property (report_done && acks_q == 3'h5);
  c_reject: cover property (byte_valid && acks_q == 3'h0 && dio[4]);
endmodule : tsr_report_chk

/* sim/tsr_host_model.sv */
// Host controller model that takes status bytes after a set delay
`timescale 1ns/1ns
module tsr_host_model (
  input  wire logic       clock,      // Clock
  input  wire logic       reset,      // Reset
  input  wire logic       clear,      // New report
  input  wire logic [3:0] delay,      // Cycles before ack
  input  wire logic [8:1] dio,        // Lines
  input  wire logic       byte_valid, // Valid
  output logic            byte_ack,   // Ack
  output logic [7:0]      rx [6],     // Bytes as on lines
  output logic [2:0]      rx_cnt      // Bytes taken
);
  logic [3:0] wait_q;
  always_ff @(posedge clock)
  begin
    if (reset || clear)
    begin
      byte_ack <= 1'b0;
      wait_q <= 4'h0;
      rx_cnt <= 3'h0;
    end
    else if (byte_ack)
    begin
      // Data taken at the edge that sees the ack, before anything moves
      byte_ack <= 1'b0;
      rx[rx_cnt] <= dio;
      rx_cnt <= rx_cnt + 3'h1;
      wait_q <= 4'h0;
    end
    else if (byte_valid)
    begin
      byte_ack <= (wait_q >= delay);
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : tsr_host_model

/* sim/tsr_status_report_bench.sv */
// Randomised bench of the tape status report
`timescale 1ns/1ns
module tsr_status_report_bench;
  logic                clock = 1'b0, reset = 1'b1, imm = 1'b0, req = 1'b0;
  logic                rvalid = 1'b0, cmd = 1'b0, valid, ack, done;
  tsr_pkg::tsr_cond_t  cond = '0;
  tsr_pkg::tsr_event_t evt = '0;
  logic [2:0]          det = 3'h0, det_m = 3'h0, rx_cnt;
  logic [7:0]          code = 8'h0, code_m = 8'h0, rx [6], w [6];
  logic [4:0]          ret = 5'h0, ret_m = 5'h0;
  logic [3:0]          delay = 4'h0;
  logic [8:1]          dio;
  logic                rej, par, pwr, tr;
  int                  errors = 0, tests_run = 0, ncmd = 0;
  always #5 clock = ~clock;
  tsr_status_report #(.RETRY_W(5)) tsr_status_report_inst (.clock(clock), .reset(reset),
    .cond(cond), .evt(evt), .immediate_mode(imm), .reject_detail(det), .error_code(code),
    .retry_count(ret), .retry_valid(rvalid), .cmd_issued(cmd), .status_req(req),
    .byte_ack(ack), .dio(dio), .byte_valid(valid), .report_done(done));
  tsr_host_model tsr_host_model_inst (.clock(clock), .reset(reset), .clear(req),
    .delay(delay), .dio(dio), .byte_valid(valid), .byte_ack(ack), .rx(rx), .rx_cnt(rx_cnt));
  task automatic step;
    @(posedge clock);
    #1;
  endtask : step
  function automatic logic [7:0] lines(input logic [7:0] x);
    return {<<{x}};
  endfunction : lines
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // ------------------------------------------------
  // Main sequence: events, retries, commands, report
  // ------------------------------------------------
  initial
  begin
    void'($urandom(32'h2ed1a841));
    {rej, par, pwr, tr} = 4'h0;
    repeat (20) @(posedge clock);
    #1 reset = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      cond = 19'($urandom);
      imm = 1'($urandom);
      delay = 4'($urandom % 4);
      evt = 4'($urandom);
      evt.reject = evt.reject | (i < 8);
      // First eight passes walk every detail code
      det = (i < 8) ? 3'(i) : 3'($urandom);
      code = 8'($urandom);
      if (evt.reject) det_m = det;
      if (evt.reject || evt.transparent) code_m = code;
      {rej, par, pwr} = {rej | evt.reject, par | evt.cmd_parity, pwr | evt.power_restored};
      if (evt.transparent) ncmd = 0;
      tr = tr | evt.transparent;
      step;
      evt = '0;
      ret = 5'($urandom);
      ret_m = ret;
      rvalid = 1'b1;
      step;
      rvalid = 1'b0;
      repeat ($urandom % 4)
      begin
        cmd = 1'b1;
        ncmd++;
        step;
        cmd = 1'b0;
        step;
      end
      w[0] = {cond.online, cond.unrecovered_error, cond.no_write_ring, rej,
              cond.single_track_error, cond.end_of_tape_flag, cond.load_point_flag,
              cond.file_mark_flag};
      w[1] = {imm, tr, cond.door_open, cond.tape_runaway, cond.timing_error,
              cond.parity_error, cond.unknown_density, cond.gcr_mode};
      w[2] = {cond.controller_error, cond.servo_error, cond.formatter_error,
              cond.position_lost, par, pwr, cond.nrzi_mode, cond.pe_mode};
      w[3] = {ret_m, det_m};
      req = 1'b1;
      step;
      req = 1'b0;
      for (int t = 0; t < 80 && done !== 1'b1; t++) step;
      chk("done", 8'h01, 8'(done));
      chk("count", imm ? 8'h6 : 8'h5, 8'(rx_cnt));
      chk("word1", lines(w[0]), rx[0]);
      chk("word2", lines(w[1]), rx[1]);
      chk("word3", lines(w[2]), rx[2]);
      chk("word4", lines(w[3]), rx[3]);
      chk("word5", lines(code_m), rx[4]);
      if (imm && tr) chk("word6", lines(8'(ncmd)), rx[5]);
      {rej, par, pwr, tr} = 4'h0;
      $display("iteration %0d done", i);
      step;
    end
    wrap_up();
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    $display("[FAIL] watchdog expected finish seen timeout");
    errors++;
    wrap_up();
  end
endmodule : tsr_status_report_bench
bind tsr_status_report tsr_report_chk tsr_report_chk_inst (.clock(clock), .reset(reset),
  .cond(cond), .immediate_mode(immediate_mode), .status_req(status_req),
  .byte_ack(byte_ack), .dio(dio), .byte_valid(byte_valid), .report_done(report_done));
